// File: core/ama_pkg.sv
// Purpose: shared constants and types for the address modifier arithmetic unit
// Assumes: 24-bit address pointers, modifier type taken from the low 16 modifier bits
// Notes: bits 23..16 of the modifier register are ignored by the type decode
`default_nettype none

package ama_pkg;

  localparam int unsigned AW = 24;
  localparam int unsigned MODW = 15;

  // modifier field positions
  localparam int unsigned MOD_TYPE_LSB = 0;
  localparam int unsigned MOD_TYPE_MSB = 15;
  localparam int unsigned MOD_WRAP_BIT = 15;
  localparam int unsigned MOD_WRAP_ZERO_BIT = 14;
  localparam int unsigned MOD_WRAP_M_MSB = 13;

  // modifier codes in the low 16 bits
  localparam logic [15:0] MOD_LINEAR = 16'hffff;
  localparam logic [15:0] MOD_REVERSE = 16'h0000;

  // values after reset
  localparam logic [AW-1:0] RST_ADDR = 24'h000000;
  localparam logic RST_VALID = 1'h0;

  // cycles from a taken request to its answer
  localparam int unsigned UPD_LATENCY = 1;

  // pointer update requested by the decoder
  typedef enum logic [2:0] {
    AMA_OP_NONE = 3'b000,
    AMA_OP_POST_INC = 3'b001,
    AMA_OP_POST_DEC = 3'b010,
    AMA_OP_POST_ADD = 3'b011,
    AMA_OP_POST_SUB = 3'b100,
    AMA_OP_INDEXED = 3'b101,
    AMA_OP_PRE_DEC = 3'b110
  } ama_op_t;

  // arithmetic selected by the modifier register
  typedef enum logic [2:0] {
    AMA_TYPE_LINEAR = 3'b000,
    AMA_TYPE_REVERSE = 3'b001,
    AMA_TYPE_MODULO = 3'b010,
    AMA_TYPE_WRAP = 3'b011,
    AMA_TYPE_RESERVED = 3'b100
  } ama_type_t;

endpackage

`default_nettype wire

// File: core/ama_unit.sv
// Purpose: address pointer update arithmetic (linear, reverse-carry, modulo, wrap-around)
// Assumes: operands and op come from logic on clk; one request may be taken every cycle
// Notes: answer stands one cycle after the request; reserved modifiers fall back to linear
`timescale 1ns/100ps
`default_nettype none

module ama_unit (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic upd_valid,
  input wire ama_pkg::ama_op_t upd_op,
  input wire logic [ama_pkg::AW-1:0] address_pointer,
  input wire logic [ama_pkg::AW-1:0] offset_register,
  input wire logic [ama_pkg::AW-1:0] modifier_register,
  output logic res_valid_q,
  output logic [ama_pkg::AW-1:0] new_pointer_q,
  output logic [ama_pkg::AW-1:0] operand_addr_q,
  output ama_pkg::ama_type_t mod_type_q,
  output logic reserved_q
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [ama_pkg::AW-1:0] bit_rev(input logic [ama_pkg::AW-1:0] v);
    logic [ama_pkg::AW-1:0] r;
    r = '0;
    for (int i = 0; i < ama_pkg::AW; i++) begin
      r[i] = v[ama_pkg::AW-1-i];
    end
    return r;
  endfunction

  // ones from the top set bit of m downward: 2^k-1 with 2^k >= m+1
  function automatic logic [ama_pkg::MODW-1:0] smear(input logic [ama_pkg::MODW-1:0] m);
    logic [ama_pkg::MODW-1:0] s;
    s = m;
    for (int i = 1; i < ama_pkg::MODW; i++) begin
      s = s | (s >> 1);
    end
    return s;
  endfunction

  function automatic ama_pkg::ama_type_t decode_type(input logic [15:0] mf);
    ama_pkg::ama_type_t t;
    t = ama_pkg::AMA_TYPE_RESERVED;
    if (mf == ama_pkg::MOD_LINEAR) begin
      t = ama_pkg::AMA_TYPE_LINEAR;
    end else if (mf == ama_pkg::MOD_REVERSE) begin
      t = ama_pkg::AMA_TYPE_REVERSE;
    end else if (!mf[ama_pkg::MOD_WRAP_BIT]) begin
      t = ama_pkg::AMA_TYPE_MODULO;
    end else if (!mf[ama_pkg::MOD_WRAP_ZERO_BIT] && mf[ama_pkg::MOD_WRAP_M_MSB:0] != 14'h0000 &&
                 smear({1'b0, mf[ama_pkg::MOD_WRAP_M_MSB:0]}) ==
                 {1'b0, mf[ama_pkg::MOD_WRAP_M_MSB:0]}) begin
      t = ama_pkg::AMA_TYPE_WRAP;
    end
    return t;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // update arithmetic

  logic res_valid_d;
  logic [ama_pkg::AW-1:0] new_pointer_d;
  logic [ama_pkg::AW-1:0] operand_addr_d;
  ama_pkg::ama_type_t mod_type_d;
  logic reserved_d;

  logic [15:0] mod_field;
  logic [ama_pkg::MODW-1:0] mod_m1;
  logic [ama_pkg::AW-1:0] blk_mask;
  logic [ama_pkg::AW-1:0] mod_size;
  logic [ama_pkg::AW-1:0] base_addr;
  logic [ama_pkg::AW-1:0] rel_addr;
  logic [ama_pkg::AW-1:0] step_mag;
  logic step_sub;
  logic [ama_pkg::AW-1:0] lin_sum;
  logic [ama_pkg::AW-1:0] upd_addr;

  always_comb begin
    logic [ama_pkg::AW-1:0] rel_new;
    rel_new = '0;
    // every pointer arrives with its own modifier, so any op meets any type
    mod_field = modifier_register[ama_pkg::MOD_TYPE_MSB:ama_pkg::MOD_TYPE_LSB];
    mod_type_d = decode_type(mod_field);
    reserved_d = (mod_type_d == ama_pkg::AMA_TYPE_RESERVED);
    mod_m1 = mod_field[ama_pkg::MODW-1:0];
    // block geometry comes from the modifier, base and offset from the pointer; nothing is stored
    blk_mask = {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, smear(mod_m1)};
    mod_size = {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, mod_m1} + 24'h000001;
    base_addr = address_pointer & ~blk_mask;
    rel_addr = address_pointer & blk_mask;

    case (upd_op)
      ama_pkg::AMA_OP_POST_INC, ama_pkg::AMA_OP_POST_DEC, ama_pkg::AMA_OP_PRE_DEC: begin
        step_mag = 24'h000001;
      end
      ama_pkg::AMA_OP_POST_ADD, ama_pkg::AMA_OP_POST_SUB, ama_pkg::AMA_OP_INDEXED: begin
        step_mag = offset_register;
      end
      default: begin
        step_mag = 24'h000000;
      end
    endcase
    step_sub = (upd_op == ama_pkg::AMA_OP_POST_DEC) || (upd_op == ama_pkg::AMA_OP_PRE_DEC) ||
               (upd_op == ama_pkg::AMA_OP_POST_SUB);

    // one adder serves signed and unsigned offsets alike
    lin_sum = step_sub ? address_pointer - step_mag : address_pointer + step_mag;

    case (mod_type_d)
      ama_pkg::AMA_TYPE_REVERSE: begin
        // carry runs MSB to LSB by working on reversed operands
        upd_addr = bit_rev(step_sub ? bit_rev(address_pointer) - bit_rev(step_mag)
                                    : bit_rev(address_pointer) + bit_rev(step_mag));
      end
      ama_pkg::AMA_TYPE_MODULO: begin
        if (step_mag != 24'h000000 && (step_mag & blk_mask) == 24'h000000) begin
          upd_addr = lin_sum;
        end else begin
          // single correction only: offsets above M are not folded further
          if (step_sub) begin
            rel_new = (rel_addr < step_mag) ? rel_addr + mod_size - step_mag
                                            : rel_addr - step_mag;
          end else begin
            rel_new = rel_addr + step_mag;
            if (rel_new > {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, mod_m1}) begin
              rel_new = rel_new - mod_size;
            end
          end
          upd_addr = base_addr | (rel_new & blk_mask);
        end
      end
      ama_pkg::AMA_TYPE_WRAP: begin
        // low k bits of the plain sum wrap any number of times
        upd_addr = base_addr | (lin_sum & blk_mask);
      end
      default: begin
        upd_addr = lin_sum;
      end
    endcase

    res_valid_d = upd_valid;
    operand_addr_d = address_pointer;
    new_pointer_d = address_pointer;
    if (upd_valid) begin
      case (upd_op)
        ama_pkg::AMA_OP_INDEXED: begin
          operand_addr_d = upd_addr;
        end
        ama_pkg::AMA_OP_PRE_DEC: begin
          operand_addr_d = upd_addr;
          new_pointer_d = upd_addr;
        end
        ama_pkg::AMA_OP_NONE: begin
          new_pointer_d = address_pointer;
        end
        default: begin
          new_pointer_d = upd_addr;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_valid_q <= ama_pkg::RST_VALID;
      new_pointer_q <= ama_pkg::RST_ADDR;
      operand_addr_q <= ama_pkg::RST_ADDR;
      mod_type_q <= ama_pkg::AMA_TYPE_LINEAR;
      reserved_q <= 1'b0;
    end else begin
      res_valid_q <= res_valid_d;
      new_pointer_q <= new_pointer_d;
      operand_addr_q <= operand_addr_d;
      mod_type_q <= mod_type_d;
      reserved_q <= reserved_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic [ama_pkg::AW-1:0] prev_base;
  logic [ama_pkg::AW-1:0] prev_mask;
  logic [ama_pkg::AW-1:0] prev_m1;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_base <= ama_pkg::RST_ADDR;
      prev_mask <= ama_pkg::RST_ADDR;
      prev_m1 <= ama_pkg::RST_ADDR;
    end else begin
      prev_base <= base_addr;
      prev_mask <= blk_mask;
      prev_m1 <= {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, mod_m1};
    end
  end

  property p_latency;
    upd_valid |=> res_valid_q ##1 (res_valid_q == $past(upd_valid));
  endproperty
  a_latency: assert property (p_latency) else $error("answer not one cycle after request");

  property p_linear_add;
    upd_valid && upd_op == ama_pkg::AMA_OP_POST_ADD &&
      mod_field == ama_pkg::MOD_LINEAR
      |=> new_pointer_q == $past(address_pointer) + $past(offset_register);
  endproperty
  a_linear_add: assert property (p_linear_add) else $error("linear add wrong");

  property p_linear_dec;
    upd_valid && upd_op == ama_pkg::AMA_OP_POST_DEC && mod_field == ama_pkg::MOD_LINEAR
      |=> new_pointer_q == $past(address_pointer) - 24'h000001 &&
          operand_addr_q == $past(address_pointer);
  endproperty
  a_linear_dec: assert property (p_linear_dec) else $error("linear step wrong");

  property p_reverse;
    upd_valid && upd_op == ama_pkg::AMA_OP_POST_ADD && mod_field == ama_pkg::MOD_REVERSE
      |=> bit_rev(new_pointer_q) ==
          bit_rev($past(address_pointer)) + bit_rev($past(offset_register));
  endproperty
  a_reverse: assert property (p_reverse) else $error("reverse carry wrong");

  property p_mod_inside;
    upd_valid && mod_type_d == ama_pkg::AMA_TYPE_MODULO && step_mag <= mod_size &&
      rel_addr <= {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, mod_m1} &&
      // a whole-block step leaves the buffer on purpose
      !(step_mag != 24'h000000 && (step_mag & blk_mask) == 24'h000000)
      |=> (new_pointer_q & ~prev_mask) == prev_base &&
          (new_pointer_q & prev_mask) <= prev_m1;
  endproperty
  a_mod_inside: assert property (p_mod_inside) else $error("modulo left buffer");

  property p_mod_top_wrap;
    upd_valid && upd_op == ama_pkg::AMA_OP_POST_INC &&
      mod_type_d == ama_pkg::AMA_TYPE_MODULO &&
      rel_addr == {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, mod_m1}
      |=> new_pointer_q == prev_base;
  endproperty
  a_mod_top_wrap: assert property (p_mod_top_wrap) else $error("no wrap to base");

  property p_mod_base_wrap;
    upd_valid && upd_op == ama_pkg::AMA_OP_POST_DEC &&
      mod_type_d == ama_pkg::AMA_TYPE_MODULO && rel_addr == 24'h000000
      |=> new_pointer_q == prev_base + prev_m1;
  endproperty
  a_mod_base_wrap: assert property (p_mod_base_wrap) else $error("no wrap to top");

  property p_mod_block_jump;
    upd_valid && upd_op == ama_pkg::AMA_OP_POST_SUB &&
      mod_type_d == ama_pkg::AMA_TYPE_MODULO && offset_register != 24'h000000 &&
      (offset_register & blk_mask) == 24'h000000
      |=> new_pointer_q == $past(address_pointer) - $past(offset_register);
  endproperty
  a_mod_block_jump: assert property (p_mod_block_jump) else $error("block jump wrong");

  property p_wrap_multi;
    upd_valid && upd_op == ama_pkg::AMA_OP_INDEXED && mod_type_d == ama_pkg::AMA_TYPE_WRAP
      |=> operand_addr_q == (prev_base | (($past(address_pointer) +
          $past(offset_register)) & prev_mask)) &&
          new_pointer_q == $past(address_pointer);
  endproperty
  a_wrap_multi: assert property (p_wrap_multi) else $error("wrap-around wrong");

  property p_wrap_decode;
    upd_valid && modifier_register[15:14] == 2'b10 &&
      modifier_register[13:0] == 14'h3fff
      |=> mod_type_q == ama_pkg::AMA_TYPE_WRAP && !reserved_q;
  endproperty
  a_wrap_decode: assert property (p_wrap_decode) else $error("wrap decode wrong");

  // wrap-around of size one is no legal code
  property p_wrap_m1;
    upd_valid && modifier_register[15:0] == 16'h8000
      |=> reserved_q && mod_type_q == ama_pkg::AMA_TYPE_RESERVED;
  endproperty
  a_wrap_m1: assert property (p_wrap_m1) else $error("wrap of one accepted");

  c_reverse: cover property (upd_valid && mod_type_d == ama_pkg::AMA_TYPE_REVERSE);
  c_mod_wrap: cover property (upd_valid && upd_op == ama_pkg::AMA_OP_POST_INC &&
    mod_type_d == ama_pkg::AMA_TYPE_MODULO &&
    rel_addr == {{(ama_pkg::AW-ama_pkg::MODW){1'b0}}, mod_m1});
  c_wrap_multi: cover property (upd_valid && mod_type_d == ama_pkg::AMA_TYPE_WRAP &&
    offset_register > mod_size);
  c_back_to_back: cover property (upd_valid ##1 upd_valid);

endmodule // ama_unit

`default_nettype wire

// File: testbench/ama_decoder_model.sv
// Purpose: decoder side that presents pointer update requests
// Assumes: caller enters issue just after a rising clk edge
// Notes: issue inverts pointer and offset once the request is taken, issue_hold does not; op and modifier stay
`timescale 1ns/100ps
`default_nettype none

module ama_decoder_model (
  input wire logic clk,
  output logic upd_valid,
  output var ama_pkg::ama_op_t upd_op,
  output logic [ama_pkg::AW-1:0] address_pointer,
  output logic [ama_pkg::AW-1:0] offset_register,
  output logic [ama_pkg::AW-1:0] modifier_register
);
  initial begin
    upd_valid = 1'h0;
    upd_op = ama_pkg::AMA_OP_NONE;
    address_pointer = 24'h000000;
    offset_register = 24'h000000;
    modifier_register = 24'hffffff;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stale pointer and offset must not look valid, so they are flipped after the edge
  task automatic issue(input ama_pkg::ama_op_t op, input logic [23:0] p,
                       input logic [23:0] n, input logic [23:0] m);
    upd_valid = 1'h1;
    upd_op = op;
    address_pointer = p;
    offset_register = n;
    modifier_register = m;
    @(posedge clk);
    #1;
    upd_valid = 1'h0;
    address_pointer = ~p;
    offset_register = ~n;
  endtask

  // leaves the request standing so that the next call follows back to back
  task automatic issue_hold(input ama_pkg::ama_op_t op, input logic [23:0] p,
                            input logic [23:0] n, input logic [23:0] m);
    upd_valid = 1'h1;
    upd_op = op;
    address_pointer = p;
    offset_register = n;
    modifier_register = m;
    @(posedge clk);
    #1;
  endtask
endmodule // ama_decoder_model

`default_nettype wire

// File: testbench/testbench.sv
// Purpose: self-checking bench for the address modifier arithmetic unit
// Assumes: one answer one cycle after each taken request
// Notes: expected pointers are worked out here from the arithmetic rules
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk;
  logic sys_rst;
  logic upd_valid;
  ama_pkg::ama_op_t upd_op;
  logic [23:0] ptr, off, modr, new_ptr, opnd;
  logic res_valid_q, reserved_q;
  ama_pkg::ama_type_t mod_type_q;
  int n_errors = 0;
  int samples_checked = 0;

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  ama_decoder_model dec (.clk(clk), .upd_valid(upd_valid), .upd_op(upd_op),
    .address_pointer(ptr), .offset_register(off), .modifier_register(modr));

  ama_unit dut (.clk(clk), .sys_rst(sys_rst), .upd_valid(upd_valid), .upd_op(upd_op),
    .address_pointer(ptr), .offset_register(off), .modifier_register(modr),
    .res_valid_q(res_valid_q), .new_pointer_q(new_ptr), .operand_addr_q(opnd),
    .mod_type_q(mod_type_q), .reserved_q(reserved_q));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [23:0] rev(input logic [23:0] v);
    logic [23:0] r;
    for (int i = 0; i < 24; i++) r[i] = v[23-i];
    return r;
  endfunction

  task automatic run(input ama_pkg::ama_op_t op, input logic [23:0] p, input logic [23:0] n,
                     input logic [23:0] m, input logic [23:0] e_new, input logic [23:0] e_op,
                     input ama_pkg::ama_type_t e_t);
    @(posedge clk);
    #1;
    dec.issue(op, p, n, m);
    check("res_valid", {23'h0, res_valid_q}, 24'h000001);
    check("new_pointer", new_ptr, e_new);
    check("operand_addr", opnd, e_op);
    check("mod_type", {21'h0, mod_type_q}, {21'h0, e_t});
    check("reserved", {23'h0, reserved_q}, {23'h0, e_t == ama_pkg::AMA_TYPE_RESERVED});
    // the answer stands one cycle, then idle shows the flipped pointer
    @(posedge clk);
    #1;
    check("idle_valid", {23'h0, res_valid_q}, 24'h000000);
    check("idle_pointer", new_ptr, ~p);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_linear;
    run(ama_pkg::AMA_OP_POST_INC, 24'hffffff, 24'h0, 24'hffffff, 24'h000000, 24'hffffff,
        ama_pkg::AMA_TYPE_LINEAR);
    run(ama_pkg::AMA_OP_POST_ADD, 24'h000010, 24'hfffff0, 24'h12ffff, 24'h000000, 24'h000010,
        ama_pkg::AMA_TYPE_LINEAR);
    run(ama_pkg::AMA_OP_POST_SUB, 24'h000005, 24'h000007, 24'hffffff, 24'hfffffe, 24'h000005,
        ama_pkg::AMA_TYPE_LINEAR);
    run(ama_pkg::AMA_OP_PRE_DEC, 24'h000000, 24'h0, 24'hffffff, 24'hffffff, 24'hffffff,
        ama_pkg::AMA_TYPE_LINEAR);
    run(ama_pkg::AMA_OP_NONE, 24'h123456, 24'h5, 24'hffffff, 24'h123456, 24'h123456,
        ama_pkg::AMA_TYPE_LINEAR);
    $display("test linear done");
  endtask

  task automatic t_reverse;
    logic [23:0] p;
    p = 24'h000000;
    for (int i = 0; i < 4; i++) begin
      run(ama_pkg::AMA_OP_POST_ADD, p, 24'h800000, 24'h000000, rev(rev(p) + 24'h000001), p,
          ama_pkg::AMA_TYPE_REVERSE);
      p = rev(rev(p) + 24'h000001);
    end
    run(ama_pkg::AMA_OP_POST_INC, 24'h000003, 24'h0, 24'h000000, rev(rev(24'h3) + 24'h800000),
        24'h000003, ama_pkg::AMA_TYPE_REVERSE);
    run(ama_pkg::AMA_OP_POST_ADD, 24'h0a5a5a, 24'h000100, 24'h000000,
        rev(rev(24'h0a5a5a) + rev(24'h000100)), 24'h0a5a5a, ama_pkg::AMA_TYPE_REVERSE);
    $display("test reverse done");
  endtask

  task automatic t_modulo;
    // m = 9 gives M = 10 in 16-word blocks
    run(ama_pkg::AMA_OP_POST_INC, 24'h000109, 24'h0, 24'h000009, 24'h000100, 24'h000109,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_DEC, 24'h000100, 24'h0, 24'h000009, 24'h000109, 24'h000100,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_ADD, 24'h000108, 24'h5, 24'h000009, 24'h000103, 24'h000108,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_SUB, 24'h000102, 24'h4, 24'h000009, 24'h000108, 24'h000102,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_INDEXED, 24'h000107, 24'h5, 24'h000009, 24'h000107, 24'h000102,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_ADD, 24'h000105, 24'h20, 24'h000009, 24'h000125, 24'h000105,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_SUB, 24'h000125, 24'h10, 24'h000009, 24'h000115, 24'h000125,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_INC, 24'h00ffff, 24'h0, 24'h007fff, 24'h008000, 24'h00ffff,
        ama_pkg::AMA_TYPE_MODULO);
    run(ama_pkg::AMA_OP_POST_INC, 24'h000011, 24'h0, 24'h000001, 24'h000010, 24'h000011,
        ama_pkg::AMA_TYPE_MODULO);
    $display("test modulo done");
  endtask

  task automatic t_wrap;
    run(ama_pkg::AMA_OP_POST_ADD, 24'h000106, 24'h13, 24'h008007, 24'h000101, 24'h000106,
        ama_pkg::AMA_TYPE_WRAP);
    run(ama_pkg::AMA_OP_POST_SUB, 24'h000101, 24'h13, 24'h008007, 24'h000106, 24'h000101,
        ama_pkg::AMA_TYPE_WRAP);
    run(ama_pkg::AMA_OP_INDEXED, 24'h000102, 24'h0f, 24'h008007, 24'h000102, 24'h000101,
        ama_pkg::AMA_TYPE_WRAP);
    run(ama_pkg::AMA_OP_POST_DEC, 24'h000100, 24'h0, 24'h008007, 24'h000107, 24'h000100,
        ama_pkg::AMA_TYPE_WRAP);
    run(ama_pkg::AMA_OP_POST_INC, 24'h00ffff, 24'h0, 24'h00bfff, 24'h00c000, 24'h00ffff,
        ama_pkg::AMA_TYPE_WRAP);
    $display("test wrap done");
  endtask

  task automatic t_reserved;
    // reserved codes fall back to linear arithmetic
    run(ama_pkg::AMA_OP_POST_INC, 24'h000010, 24'h0, 24'h00c000, 24'h000011, 24'h000010,
        ama_pkg::AMA_TYPE_RESERVED);
    run(ama_pkg::AMA_OP_POST_INC, 24'h00001f, 24'h0, 24'h008002, 24'h000020, 24'h00001f,
        ama_pkg::AMA_TYPE_RESERVED);
    run(ama_pkg::AMA_OP_POST_INC, 24'h000033, 24'h0, 24'h008000, 24'h000034, 24'h000033,
        ama_pkg::AMA_TYPE_RESERVED);
    $display("test reserved done");
  endtask

  task automatic t_back_to_back;
    // modulo then wrap-around on consecutive edges, each with its own modifier
    @(posedge clk);
    #1;
    dec.issue_hold(ama_pkg::AMA_OP_POST_INC, 24'h000209, 24'h0, 24'h000009);
    check("b2b_valid_a", {23'h0, res_valid_q}, 24'h000001);
    check("b2b_new_a", new_ptr, 24'h000200);
    dec.issue(ama_pkg::AMA_OP_POST_ADD, 24'h000106, 24'h13, 24'h008007);
    check("b2b_valid_b", {23'h0, res_valid_q}, 24'h000001);
    check("b2b_new_b", new_ptr, 24'h000101);
    check("b2b_type_b", {21'h0, mod_type_q}, {21'h0, ama_pkg::AMA_TYPE_WRAP});
    $display("test back to back done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    $display("Error watchdog expected done seen hang");
    conclude();
  end

  initial begin
    sys_rst = 1'h1;
    repeat (20) @(posedge clk);
    #1;
    sys_rst = 1'h0;
    check("reset_valid", {23'h0, res_valid_q}, 24'h000000);
    check("reset_type", {21'h0, mod_type_q}, {21'h0, ama_pkg::AMA_TYPE_LINEAR});
    t_linear();
    t_reverse();
    t_modulo();
    t_wrap();
    t_reserved();
    t_back_to_back();
    conclude();
  end
endmodule // testbench

`default_nettype wire
